// ==== hsc_strap_reset.sv ====
// Purpose: Strap latching, host interface select, output clock,
//          reset merge and interrupt merge with APB registers
// Assumes: Pins and regulator resets are asynchronous to clk;
//          event inputs are one-cycle pulses on clk
// Notes:   No interrupt flag is lost to a clear in the same cycle
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module hsc_strap_reset
  import hsc_pkg::*;
#(
  parameter int unsigned NIRQ = 16
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    hard_reset_n,
  input  wire logic                    power_on_reset_n,
  input  wire logic                    low_voltage_reset_n,
  input  wire logic                    host_if_strap_lo,
  input  wire logic                    host_if_strap_hi,
  input  wire logic [1:0]              ext_clk_strap,
  input  wire logic [NIRQ-1:0]         irq_src_main,
  input  wire logic [NIRQ-1:0]         irq_src_startup,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [hsc_pkg::AW-1:0]  paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         ext_output_clock,
  output logic                         host_irq_n,
  output hsc_pkg::hsc_host_if_t        host_if_mode,
  output logic                         core_run,
  output logic                         config_mode,
  output logic                         net_join_en
);
  import hsc_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Input synchronisers
  localparam int unsigned NS = 7;
  logic [NS-1:0] pin_raw;       // Asynchronous pins
  logic [NS-1:0] meta_q;        // First stage, read by sync_q only
  logic [NS-1:0] sync_q;        // Second stage, safe to use

  assign pin_raw = {hard_reset_n, power_on_reset_n, low_voltage_reset_n,
                    host_if_strap_hi, host_if_strap_lo, ext_clk_strap};

  // One two-stage chain per pin
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin_raw[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  logic       hard_ok;          // Hard reset released
  logic       int_ok;           // Power-on and low-voltage released
  logic       any_rst;          // Some reset active
  logic [1:0] if_strap_s;       // Synced interface straps
  logic [1:0] ck_strap_s;       // Synced clock straps

  assign hard_ok    = sync_q[6];
  assign int_ok     = sync_q[5] && sync_q[4];
  assign any_rst    = !(hard_ok && int_ok);
  assign if_strap_s = sync_q[3:2];
  assign ck_strap_s = sync_q[1:0];

  ////////////////////////////////////////////////////////////////////
  // Reset sequencer and strap latches
  hsc_state_t st_q, st_d;       // Only one operating mode exists
  logic [1:0] if_lat_q, if_lat_d;  // Held interface straps
  logic [1:0] ck_lat_q, ck_lat_d;  // Held clock straps
  logic       ck_chg;           // Clock selection changes now

  // Latch straps at release; decide run or halt from the latch
  always_comb begin
    st_d     = st_q;
    if_lat_d = if_lat_q;
    ck_lat_d = ck_lat_q;
    unique case (st_q)
      ST_RST: begin
        if (!any_rst) begin
          if_lat_d = if_strap_s;
          ck_lat_d = ck_strap_s;
          // A bad code halts until the next hard, power-on or low-voltage reset
          st_d = (if_strap_s == HIF_ASYNC_MEM ||
                  if_strap_s == HIF_MCU_BUS) ? ST_RUN : ST_HALT;
        end
      end
      ST_RUN, ST_HALT: begin
        if (any_rst) st_d = ST_RST;
      end
      default: st_d = ST_RST;
    endcase
  end

  // Register only; the clock latch keeps its value across hard reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= ST_RST;
      if_lat_q <= HIF_ASYNC_MEM;
      ck_lat_q <= CKS_OFF;
    end else begin
      st_q     <= st_d;
      if_lat_q <= if_lat_d;
      ck_lat_q <= ck_lat_d;
    end
  end

  assign ck_chg = (ck_lat_d != ck_lat_q);

  // Mode from the held latch, never the live pins
  assign host_if_mode = hsc_host_if_t'(if_lat_q);
  assign core_run     = (st_q == ST_RUN);
  assign config_mode  = (st_q != ST_RUN);
  assign net_join_en  = (st_q == ST_RUN);

  ////////////////////////////////////////////////////////////////////
  // Output clock
  logic [CW-1:0] hi_cyc, lo_cyc;  // Phase lengths for the selection
  logic          ck_run;          // Divider allowed to run

  // Map the code being latched to divider phases
  // Taken from the next latch value so that a restart at release
  // already loads the new ratio, not the one being replaced
  always_comb begin
    unique case (ck_lat_d)
      CKS_LO: begin
        hi_cyc = CW'(DIV_LO / 2);
        lo_cyc = CW'(DIV_LO - DIV_LO / 2);
      end
      CKS_MID: begin
        hi_cyc = CW'(DIV_MID / 2);
        lo_cyc = CW'(DIV_MID - DIV_MID / 2);
      end
      CKS_HI: begin
        hi_cyc = CW'(DIV_HI / 2);
        lo_cyc = CW'(DIV_HI - DIV_HI / 2);
      end
      CKS_OFF: begin
        hi_cyc = CW'(1);
        lo_cyc = CW'(1);
      end
    endcase
  end

  // Runs through hard reset, stops for the regulator resets
  // Hard reset never clears the latch, so the clock keeps running
  assign ck_run = int_ok && (ck_lat_d != CKS_OFF);

  // Restart on a new ratio so it settles at once
  hsc_clk_div #(.W(CW)) u_div (
    .clk     (clk),
    .nrst    (nrst),
    .run     (ck_run),
    .restart (ck_chg),
    .hi_cyc  (hi_cyc),
    .lo_cyc  (lo_cyc),
    .clk_out (ext_output_clock)
  );

  ////////////////////////////////////////////////////////////////////
  // APB register file
  logic [NIRQ-1:0] ism_q, ism_d;  // Main status, write one to clear
  logic [NIRQ-1:0] sis_q, sis_d;  // Startup status
  logic [NIRQ-1:0] iem_q, iem_d;  // Main enable
  logic [NIRQ-1:0] sie_q, sie_d;  // Startup enable
  logic [31:0]     rd_q, rd_d;    // Read data, loaded at setup
  logic            err_q, err_d;  // Unmapped address seen at setup
  logic            irqn_q, irqn_d;
  logic            setup, wr;     // Setup phase, committing write
  logic            pend;          // Enabled source pending
  logic            hit;           // Address decodes

  assign setup = psel && !penable;
  // Halted core drops writes entirely
  assign wr    = psel && penable && pwrite && core_run;
  assign hit   = (paddr == A_ISM) || (paddr == A_SIS) ||
                 (paddr == A_IEM) || (paddr == A_SIE) ||
                 (paddr == A_CFG);

  // Status: new events beat a same-cycle clear
  always_comb begin
    ism_d = ism_q;
    sis_d = sis_q;
    iem_d = iem_q;
    sie_d = sie_q;
    if (any_rst) begin
      ism_d = '0;
      sis_d = '0;
      iem_d = '0;
      sie_d = '0;
    end else begin
      if (wr && paddr == A_ISM) ism_d = ism_q & ~pwdata[NIRQ-1:0];
      if (wr && paddr == A_SIS) sis_d = sis_q & ~pwdata[NIRQ-1:0];
      if (wr && paddr == A_IEM) iem_d = pwdata[NIRQ-1:0];
      if (wr && paddr == A_SIE) sie_d = pwdata[NIRQ-1:0];
      if (core_run) begin
        ism_d = ism_d | irq_src_main;
        sis_d = sis_d | irq_src_startup;
      end
    end
  end

  // Read data is captured in setup so prdata comes from a flop
  always_comb begin
    rd_d  = rd_q;
    err_d = err_q;
    if (setup) begin
      rd_d  = '0;
      err_d = core_run && !hit;
      if (core_run) begin
        unique case (paddr)
          A_ISM:   rd_d[NIRQ-1:0] = ism_q;
          A_SIS:   rd_d[NIRQ-1:0] = sis_q;
          A_IEM:   rd_d[NIRQ-1:0] = iem_q;
          A_SIE:   rd_d[NIRQ-1:0] = sie_q;
          A_CFG: begin
            rd_d[CFG_MODE_LSB +: 2] = if_lat_q;
            rd_d[CFG_HALT_BIT]      = 1'b0;
            rd_d[CFG_CKS_LSB +: 2]  = ck_lat_q;
            rd_d[CFG_JOIN_BIT]      = net_join_en;
          end
          default: rd_d = '0;
        endcase
      end
    end
  end

  // One line, low while any enabled flag is set
  assign pend   = |(ism_q & iem_q) || |(sis_q & sie_q);
  assign irqn_d = !pend;

  // Register only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ism_q  <= '0;
      sis_q  <= '0;
      iem_q  <= '0;
      sie_q  <= '0;
      rd_q   <= '0;
      err_q  <= 1'b0;
      irqn_q <= 1'b1;
    end else begin
      ism_q  <= ism_d;
      sis_q  <= sis_d;
      iem_q  <= iem_d;
      sie_q  <= sie_d;
      rd_q   <= rd_d;
      err_q  <= err_d;
      irqn_q <= irqn_d;
    end
  end

  // Zero-wait access phase; a halted core answers zero, no error
  assign pready     = 1'b1;
  assign prdata     = rd_q;
  assign pslverr    = err_q && psel && penable;
  assign host_irq_n = irqn_q;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_latch_hold;
    // The latch may move only on the edge that leaves reset
    (st_q != ST_RST) |=> $stable(if_lat_q);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("Interface latch moved outside reset");

  property p_mode_latch;
    (st_q == ST_RST && !any_rst) |=> (if_lat_q == $past(if_strap_s));
  endproperty
  a_mode_latch: assert property (p_mode_latch)
    else $error("Interface latch missed strap at release");

  property p_halt_quiet;
    (st_q == ST_HALT && psel && penable && pwrite) |=>
      $stable(iem_q) && $stable(sie_q);
  endproperty
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("Write took effect while halted");

  property p_halt_nojoin;
    (st_q == ST_HALT) |-> config_mode && !net_join_en && !core_run;
  endproperty
  a_halt_nojoin: assert property (p_halt_nojoin)
    else $error("Halted core joined or ran");

  property p_clk_off;
    (!int_ok || ck_lat_d == CKS_OFF) |=> !ext_output_clock;
  endproperty
  a_clk_off: assert property (p_clk_off)
    else $error("Output clock ran while disabled");

  property p_clk_hard;
    (int_ok && !hard_ok && ck_lat_q == CKS_HI) |->
      ##[1:5] ext_output_clock;
  endproperty
  a_clk_hard: assert property (p_clk_hard)
    else $error("Output clock stopped in hard reset");

  property p_clk_settle;
    (ck_chg && int_ok && ck_lat_d != CKS_OFF) |=> ext_output_clock;
  endproperty
  a_clk_settle: assert property (p_clk_settle)
    else $error("Output clock did not restart promptly");

  property p_irq_level;
    pend |=> !host_irq_n;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Pending source not on request line");

  property p_irq_idle;
    !pend |=> host_irq_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle)
    else $error("Request line low with nothing pending");

  property p_rst_clear;
    any_rst |=> (ism_q == '0) && (iem_q == '0) && (sie_q == '0);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("Registers not cleared by reset");

  property p_set_wins;
    // Every main event bit of a running cycle must show in the main status
    (core_run && !any_rst && |irq_src_main) |=>
      ((ism_q & $past(irq_src_main)) == $past(irq_src_main));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Main event lost");

endmodule : hsc_strap_reset

// ==== hsc_pkg.sv ====
// Purpose: Shared constants and types of the strap, clock-out and
//          reset block of the communication controller
// Assumes: clk is the controller input clock, 200 MHz
// Notes:   Register offsets are word indices; byte address = 4*index
//
// Notes on behaviour
// - Latch interface straps when hard reset ends
// - Host interface type comes from latched straps
// - Unsupported straps halt core, ignore host accesses
// - Unsupported straps: stay configuring, never join network
// - Output clock off, or 4, 10, 40 MHz
// - Two clock straps select enable and frequency
// - Output clock runs during hard reset too
// - Output clock off during power-on, low-voltage reset
// - Output clock stable within 8 microticks
// - All interrupt sources merge onto one line
// - Request held while enabled source is pending
// - Main and startup status/enable register pairs
// - Hard, power-on and low-voltage resets honoured
// - Any reset forces defined startup values
// - Single normal mode, no power saving
// - Interrupt request output is active low
// - Hard reset input is active low
// - One microtick is one input clock period
package hsc_pkg;

  // Clock rate and microtick
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned UTICK_CYC   = 1;
  localparam int unsigned SETTLE_UT   = 8;   // Clock settle, microticks
  localparam int unsigned SETTLE_CYC  = SETTLE_UT * UTICK_CYC;

  // Output clock frequencies in MHz and derived divider ratios
  localparam int unsigned F_LO_MHZ  = 4;
  localparam int unsigned F_MID_MHZ = 10;
  localparam int unsigned F_HI_MHZ  = 40;
  localparam int unsigned DIV_LO  = CLK_HZ / (F_LO_MHZ * 1_000_000);
  localparam int unsigned DIV_MID = CLK_HZ / (F_MID_MHZ * 1_000_000);
  localparam int unsigned DIV_HI  = CLK_HZ / (F_HI_MHZ * 1_000_000);
  localparam int unsigned CW      = 8;   // Divider counter width

  // Clock strap codes
  localparam logic [1:0] CKS_OFF = 2'h0;
  localparam logic [1:0] CKS_LO  = 2'h1;
  localparam logic [1:0] CKS_MID = 2'h2;
  localparam logic [1:0] CKS_HI  = 2'h3;

  // Register word indices and byte addresses
  localparam int unsigned AW = 12;
  localparam logic [9:0] IDX_IRQ_STATUS_MAIN     = 10'h00E;
  localparam logic [9:0] IDX_STARTUP_IRQ_STATUS  = 10'h010;
  localparam logic [9:0] IDX_IRQ_ENABLE_MAIN     = 10'h014;
  localparam logic [9:0] IDX_STARTUP_IRQ_ENABLE  = 10'h016;
  localparam logic [9:0] IDX_CFG_STATUS          = 10'h040;
  localparam logic [AW-1:0] A_ISM = {IDX_IRQ_STATUS_MAIN, 2'h0};
  localparam logic [AW-1:0] A_SIS = {IDX_STARTUP_IRQ_STATUS, 2'h0};
  localparam logic [AW-1:0] A_IEM = {IDX_IRQ_ENABLE_MAIN, 2'h0};
  localparam logic [AW-1:0] A_SIE = {IDX_STARTUP_IRQ_ENABLE, 2'h0};
  localparam logic [AW-1:0] A_CFG = {IDX_CFG_STATUS, 2'h0};

  // Config status fields
  localparam int unsigned CFG_MODE_LSB = 0;
  localparam int unsigned CFG_HALT_BIT = 2;
  localparam int unsigned CFG_CKS_LSB  = 3;
  localparam int unsigned CFG_JOIN_BIT = 5;

  // Host interface strap codes {hi, lo}
  typedef enum logic [1:0] {
    HIF_ASYNC_MEM = 2'h0,
    HIF_MCU_BUS   = 2'h1
  } hsc_host_if_t;

  // Top sequencer states
  typedef enum logic [2:0] {
    ST_RST  = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } hsc_state_t;

endpackage : hsc_pkg

// ==== hsc_clk_div.sv ====
// Purpose: Divider that makes the external output clock
// Assumes: hi_cyc and lo_cyc are at least one
// Notes:   Restart restarts the period at once so a new ratio
//          settles within a single cycle
`timescale 1ns/1ps
module hsc_clk_div #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         run,
  input  wire logic         restart,
  input  wire logic [W-1:0] hi_cyc,
  input  wire logic [W-1:0] lo_cyc,
  output logic              clk_out
);
  logic [W-1:0] cnt_q, cnt_d;   // Cycles left in this phase
  logic         out_q, out_d;   // Output level

  // Next phase and count; stopped output sits low
  always_comb begin
    cnt_d = cnt_q;
    out_d = out_q;
    if (!run || restart) begin
      cnt_d = hi_cyc - W'(1);
      out_d = run;
    end else if (cnt_q == '0) begin
      out_d = !out_q;
      cnt_d = out_q ? lo_cyc - W'(1) : hi_cyc - W'(1);
    end else begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Register only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign clk_out = out_q;
endmodule : hsc_clk_div

// ==== hsc_host_model.sv ====
// Purpose: Host side of the register bus, an APB master
// Assumes: Tasks are entered just after a rising clk edge
// Notes:   One idle cycle follows each transfer, so no signal is
//          driven twice in one time step
`timescale 1ns/1ps
module hsc_host_model (
  input  wire logic                   clk,
  input  wire logic [31:0]            prdata,
  input  wire logic                   pready,
  input  wire logic                   pslverr,
  output logic                        psel,
  output logic                        penable,
  output logic                        pwrite,
  output logic [hsc_pkg::AW-1:0]      paddr,
  output logic [31:0]                 pwdata
);
  import hsc_pkg::*;

  // Bus idle at time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = 32'h0;
  end

  // One transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [AW-1:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // No latency is assumed; only the bench timeout ends this wait
    while (pready !== 1'b1) @(posedge clk);
    r        = prdata;
    err      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : xfer
endmodule : hsc_host_model

// ==== host_if_strap_ext_output_clock_reset_tb.sv ====
// Purpose: Self-checking bench of the strap, clock-out, reset block
// Assumes: 200 MHz clk; strap and reset pins driven on rising edges
// Notes:   Register contents are mirrored in int arrays m_st, m_en
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
  error_cnt++; \
  $display("mismatch at %0t: got %0h exp %0h", $time, g, e); end end
module host_if_strap_ext_output_clock_reset_tb;
  import hsc_pkg::*;

  logic             clk = 1'b0;  // Controller clock
  logic             nrst = 1'b0;  // Power reset
  logic             hrst_n = 1'b0;  // Hard reset pin
  logic             por_n = 1'b1;  // Regulator power-on reset
  logic             lv_rst_n = 1'b1;  // Regulator low-voltage reset
  logic             if_lo = 1'b0;  // Interface straps
  logic             if_hi = 1'b0;
  logic [1:0]       cks = 2'h0;  // Clock straps
  logic [15:0]      src_m = 16'h0;  // Event pulses
  logic [15:0]      src_s = 16'h0;
  logic             psel, penable, pwrite, pready, pslverr;
  logic [AW-1:0]    paddr;
  logic [31:0]      pwdata, prdata, rd;
  logic             er, ck_o, irq_n, run, cfg_m, join_en;
  hsc_host_if_t     mode;
  int               error_cnt = 0, n_compared = 0, cyc = 0, h, l;
  int               m_st[2], m_en[2];  // Status and enable mirror
  int               eh[4] = '{0, 25, 10, 2};  // High cycles per code
  int               el[4] = '{0, 25, 10, 3};  // Low cycles per code

  always #2.5 clk = ~clk;

  hsc_strap_reset i_dut (.clk(clk), .nrst(nrst), .hard_reset_n(hrst_n),
    .power_on_reset_n(por_n), .low_voltage_reset_n(lv_rst_n),
    .host_if_strap_lo(if_lo), .host_if_strap_hi(if_hi),
    .ext_clk_strap(cks), .irq_src_main(src_m), .irq_src_startup(src_s),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_output_clock(ck_o), .host_irq_n(irq_n),
    .host_if_mode(mode), .core_run(run), .config_mode(cfg_m),
    .net_join_en(join_en));

  hsc_host_model i_host (.clk(clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  ////////////////////////////////////////////////////////////////////
  // Closing report, reached from the main flow or the timeout
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // Hang guard, several times the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read and compare data and error response
  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] e,
                        input logic ee);
    i_host.xfer(1'b0, a, 32'h0, rd, er);
    `CHK(rd, e)
    `CHK(er, ee)
  endtask : rd_chk

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, er);
  endtask : wr

  // Bounded wait for the run state; halted boots never get there
  task automatic wait_run;
    for (int n = 0; n < 10 && run !== 1'b1; n++) @(posedge clk);
  endtask : wait_run

  // High and low cycle counts of one output clock period
  task automatic meas(output int hc, output int lc);
    int n;
    hc = 0;
    lc = 0;
    n  = 0;
    while (ck_o !== 1'b0 && n < 200) begin @(posedge clk); n++; end
    while (ck_o !== 1'b1 && n < 200) begin @(posedge clk); n++; end
    while (ck_o === 1'b1 && hc < 200) begin @(posedge clk); hc++; end
    while (ck_o === 1'b0 && lc < 200) begin @(posedge clk); lc++; end
  endtask : meas

  // One-cycle event pulse on the main (0) or startup (1) sources
  task automatic pulse(input int k, input int b);
    if (k == 0) src_m <= 16'h1 << b;
    else src_s <= 16'h1 << b;
    @(posedge clk);
    src_m <= 16'h0;
    src_s <= 16'h0;
    @(posedge clk);
  endtask : pulse

  function automatic logic [AW-1:0] st_a(input int k);
    return (k == 0) ? A_ISM : A_SIS;
  endfunction : st_a

  function automatic logic [AW-1:0] en_a(input int k);
    return (k == 0) ? A_IEM : A_SIE;
  endfunction : en_a

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int ck, b, nb;
    void'($urandom(32'hEB15));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    // Every interface code with a different clock code; i=4 recovers
    for (int i = 0; i < 5; i++) begin
      ck = (i == 4) ? 2 : 3 - i;
      hrst_n <= 1'b0;
      if_lo  <= i[0];
      if_hi  <= i[1] & (i != 4);
      cks    <= ck[1:0];
      @(posedge clk);
      if (i > 0) begin
        meas(h, l);
        `CHK(h, eh[4 - i])
      end
      repeat (3) @(posedge clk);
      hrst_n <= 1'b1;
      wait_run();
      repeat (SETTLE_CYC) @(posedge clk);
      // Live strap changes must not matter once latched
      if_lo <= ~if_lo;
      cks   <= ~cks;
      meas(h, l);  // Ratio must already be steady here
      `CHK(h, eh[ck])
      if (ck != 0) `CHK(l, el[ck])
      `CHK(run, (i < 2 || i == 4))
      `CHK(cfg_m, !(i < 2 || i == 4))
      `CHK(join_en, (i < 2 || i == 4))
      if (i < 2 || i == 4) begin
        `CHK(mode, hsc_host_if_t'(i[0]))
        rd_chk(A_CFG, 32'h20 | (ck << 3) | i[0], 1'b0);
      end else begin
        wr(A_IEM, 32'hFFFF);
        rd_chk(A_IEM, 32'h0, 1'b0);
      end
      $display("test boot %0d done", i);
    end
    // Unmapped place answers with an error and no data
    rd_chk(12'h004, 32'h0, 1'b1);
    // Interrupt pairs: masked event, enabled event, clear
    for (int k = 0; k < 2; k++) begin
      m_st[k] = 0;
      b  = $urandom_range(15, 0);
      nb = (b + 1) % 16;
      m_en[k] = 1 << b;
      wr(en_a(k), m_en[k]);
      pulse(k, nb);
      repeat (2) @(posedge clk);
      `CHK(irq_n, 1'b1)
      m_st[k] |= 1 << nb;
      rd_chk(st_a(k), m_st[k], 1'b0);
      pulse(k, b);
      repeat (2) @(posedge clk);
      `CHK(irq_n, 1'b0)
      m_st[k] |= 1 << b;
      repeat (6) @(posedge clk);
      `CHK(irq_n, 1'b0)
      wr(st_a(k), m_st[k]);
      m_st[k] = 0;
      repeat (2) @(posedge clk);
      `CHK(irq_n, 1'b1)
      rd_chk(st_a(k), m_st[k], 1'b0);
      m_en[k] = $urandom();
      wr(en_a(k), m_en[k]);
      rd_chk(en_a(k), m_en[k] & 32'hFFFF, 1'b0);
      $display("test irq pair %0d done", k);
    end
    // Regulator resets stop the clock and clear the registers
    for (int j = 0; j < 2; j++) begin
      if (j == 0) por_n <= 1'b0;
      else lv_rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      meas(h, l);
      `CHK(h, 0)
      `CHK(run, 1'b0)
      por_n <= 1'b1;
      lv_rst_n <= 1'b1;
      wait_run();
      m_en[0] = 0;
      rd_chk(A_IEM, m_en[0], 1'b0);
      $display("test regulator reset %0d done", j);
    end
    summarize();
  end
endmodule : host_if_strap_ext_output_clock_reset_tb
